/* File: design/addr_defines.svh */
`ifndef ADDR_DEFINES_SVH
`define ADDR_DEFINES_SVH
// register byte offsets
`define OFS_MODE        4'h0
`define OFS_SLOT_ZERO   4'h1
`define OFS_SLOT_ONE    4'h2
`define OFS_STATE       4'h3
`define OFS_INT_ONE     4'h4
`define OFS_INT_TWO     4'h5
`define OFS_MASK_ONE    4'h6
`define OFS_AUX_CMD     4'h7
`define OFS_OUT_BYTE    4'h8
`define OFS_IN_BYTE     4'h9
`define OFS_PASSTHRU    4'hA
`define OFS_DMA_CTRL    4'hB
// address_state_reg fields
`define ST_MAJOR_MINOR  0
`define ST_LISTEN_ADR   1
`define ST_SEND_ADR     2
`define ST_LISTEN_PRIMARY_SEEN         3
`define ST_TALK_PRIMARY_SEEN         4
`define ST_ATN_REL      5
`define ST_ACTIVE_CTL   6
// int_status_one fields
`define I1_INBOUND      0
`define I1_OUTBOUND     1
`define I1_SECONDARY    2
// int_status_two fields
`define I2_ADDR_CHANGE  0
// aux command codes
`define AUX_VALID       8'h0F
`define AUX_NON_VALID   8'h07
// reset values
`define RST_MODE        2'h1
`define RST_BYTE        8'h00
// bus command byte groups
`define GRP_LISTEN      2'h1
`define GRP_TALK        2'h2
`define GRP_SECONDARY   2'h3
`endif

/* File: design/addr_pkg.sv */
package addr_pkg;
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_DUAL = 2'h1,
        MODE_EXT  = 2'h2,
        MODE_SOFT = 2'h3
    } addr_mode_t;
    typedef enum logic [1:0] {
        SEC_IDLE = 2'h0,
        SEC_HOLD = 2'h1
    } sec_state_t;
    typedef enum logic [1:0] {
        CMD_PCG_OTHER = 2'h0,
        CMD_LISTEN    = 2'h1,
        CMD_TALK      = 2'h2,
        CMD_SECONDARY = 2'h3
    } cmd_group_t;
endpackage

/* File: design/bus_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_sync (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // raw pin levels
    input  wire logic [9:0] raw_in,
    // synchronised levels
    output logic      [9:0] sync_out
);
    typedef struct packed {
        logic [9:0] meta;
        logic [9:0] stable;
    } sync_state_t;
    sync_state_t st_ff;
    sync_state_t nxt_st;
    // first stage read only by the second stage
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = raw_in;
        nxt_st.stable = st_ff.meta;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle bus lines read high; zeros here would fake a byte strobe after reset
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign sync_out = st_ff.stable;
endmodule
`default_nettype wire

/* File: design/cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "addr_defines.svh"
module cmd_decode (
    // command byte and own addresses
    input  wire logic [7:0]  cmd_byte,
    input  wire logic [4:0]  slot_zero,
    input  wire logic [4:0]  slot_one,
    // decoded group and matches
    output addr_pkg::cmd_group_t grp,
    output logic             hit_zero,
    output logic             hit_one,
    output logic             is_pcg
);
    import addr_pkg::*;
    // bits 6:5 pick the group, the low five are the address
    always_comb begin
        grp      = cmd_group_t'(cmd_byte[6:5]);
        hit_zero = (cmd_byte[4:0] == slot_zero);
        hit_one  = (cmd_byte[4:0] == slot_one);
        is_pcg   = (cmd_byte[6:5] != `GRP_SECONDARY);
    end
endmodule
`default_nettype wire

/* File: design/talk_listen_controller.sv */
// Notes on behaviour
// - active_ctl is never set; the controller's own addressing is not counted
// - mode 1 matches major and minor primaries
// - talk address sets send and change flags
// - listen address sets listen and change flags
// - major_minor_bit tells which address matched
// - mode 2 needs primary then secondary match
// - mode 2 primary talk sets talk_primary_seen
// - mode 2 secondary completes talker or listener
// - mode 3 secondary matched by software
// - mode 3 primary sets primary seen flags
// - mode 3 secondary flags and holds DAC
// - Valid sets role and releases DAC
// - Non-Valid idles role and releases DAC
// - each further secondary repeats the holdoff
// - primary command before secondary clears seen
// - data by DMA or PIO, PIO default
// - talker requests DMA when outbound empty
// - listener requests DMA when inbound full
// - one fly-by DMA cycle per byte
// - talker and listener exclude each other
// - state read from ATN, send, listen bits
`timescale 1ns/1ps
`default_nettype none
`include "addr_defines.svh"
module talk_listen_controller (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // avalon-mm slave
    input  wire logic [3:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic            avs_waitrequest,
    // instrument bus pins, active low
    input  wire logic [7:0] dio_n_in,
    input  wire logic       atn_n_in,
    input  wire logic       dav_n_in,
    output logic            dac_n_out,
    output logic            dac_n_oe_n,
    output logic            rfd_n_out,
    output logic            rfd_n_oe_n,
    output logic            dav_n_out,
    output logic            dav_n_oe_n,
    output logic      [7:0] dio_n_out,
    output logic            dio_n_oe_n,
    input  wire logic       dac_n_in,
    // fly-by dma
    output logic            dma_req,
    input  wire logic       dma_ack,
    input  wire logic [7:0] dma_wdata,
    output logic      [7:0] dma_rdata,
    // secondary address interrupt line
    output logic            secondary_irq
);
    import addr_pkg::*;
    typedef struct packed {
        addr_mode_t  mode;
        logic [4:0]  slot_zero;
        logic [4:0]  slot_one;
        logic        send_addressed;
        logic        listen_addressed;
        logic        major_minor;
        logic        talk_primary_seen;
        logic        listen_primary_seen;
        logic        active_ctl;
        logic        inbound_ready;
        logic        outbound_ready;
        logic        secondary_seen;
        logic        addr_change;
        logic        sec_int_en;
        logic        dma_en;
        sec_state_t  sec;
        logic [7:0]  out_byte;
        logic        out_full;
        logic [7:0]  in_byte;
        logic [7:0]  passthru;
        logic        dav_seen;
        logic        prim_pending;
        logic        talk_drive;
        logic        dav_drive;
        logic [31:0] rdata;
        logic        ack;
    } tlc_state_t;
    tlc_state_t st_ff;
    tlc_state_t nxt_st;
    logic [9:0]  sync_lv;
    logic [7:0]  bus_byte;
    logic        atn_asserted;
    logic        dav_asserted;
    logic        dac_asserted;
    cmd_group_t  grp;
    logic        hit_zero;
    logic        hit_one;
    logic        is_pcg;
    logic        new_byte;
    logic        hold_dac;
    logic        acc_wr;
    logic        acc_rd;
    logic        hit_prim;
    logic        is_major;
    // pins come from another domain
    bus_sync u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .raw_in   ({dac_n_in, dav_n_in, dio_n_in}),
        .sync_out (sync_lv)
    );
    assign bus_byte     = ~sync_lv[7:0];
    assign dav_asserted = ~sync_lv[8];
    // the acceptance line reads high once every acceptor has released it
    assign dac_asserted = sync_lv[9];
    // atn is a level only; sampled once more through its own stage pair
    logic [1:0] atn_sync_ff;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            atn_sync_ff <= 2'h3;
        end else begin
            atn_sync_ff <= {atn_sync_ff[0], atn_n_in};
        end
    end
    assign atn_asserted = ~atn_sync_ff[1];
    cmd_decode u_dec (
        .cmd_byte  (bus_byte),
        .slot_zero (st_ff.slot_zero),
        .slot_one  (st_ff.slot_one),
        .grp       (grp),
        .hit_zero  (hit_zero),
        .hit_one   (hit_one),
        .is_pcg    (is_pcg)
    );
    // mode 2 only watches slot zero as primary
    assign hit_prim = (st_ff.mode == MODE_EXT) ? hit_zero : (hit_zero | hit_one);
    assign is_major = hit_zero;
    assign new_byte = dav_asserted & ~st_ff.dav_seen;
    assign hold_dac = (st_ff.sec == SEC_HOLD);
    assign acc_wr   = avs_write & ~st_ff.ack;
    assign acc_rd   = avs_read & ~st_ff.ack;
    // one wait cycle then the answer
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = acc_wr | acc_rd;
        if (!dav_asserted) begin
            nxt_st.dav_seen = 1'b0;
        end
        // cleared ahead of the events below, so a same-cycle change still wins
        if (acc_rd && avs_address == `OFS_INT_TWO) begin
            nxt_st.addr_change = 1'b0;
        end
        // bus byte handling
        if (new_byte && !hold_dac) begin
            nxt_st.dav_seen = 1'b1;
            if (atn_asserted) begin
                if (is_pcg) begin
                    nxt_st.prim_pending = 1'b0;
                end
                if (is_pcg && st_ff.mode != MODE_DUAL) begin
                    nxt_st.talk_primary_seen = 1'b0;
                    nxt_st.listen_primary_seen = 1'b0;
                end
                case (grp)
                    CMD_TALK: begin
                        if (hit_prim && st_ff.mode == MODE_DUAL) begin
                            nxt_st.send_addressed   = 1'b1;
                            nxt_st.listen_addressed = 1'b0;
                            nxt_st.addr_change      = 1'b1;
                            nxt_st.major_minor      = ~is_major;
                        end else if (hit_prim && st_ff.mode != MODE_OFF) begin
                            nxt_st.talk_primary_seen         = 1'b1;
                            nxt_st.listen_primary_seen         = 1'b0;
                            nxt_st.major_minor  = ~is_major;
                            nxt_st.prim_pending = 1'b1;
                        end
                    end
                    CMD_LISTEN: begin
                        if (hit_prim && st_ff.mode == MODE_DUAL) begin
                            nxt_st.listen_addressed = 1'b1;
                            nxt_st.send_addressed   = 1'b0;
                            nxt_st.addr_change      = 1'b1;
                            nxt_st.major_minor      = ~is_major;
                        end else if (hit_prim && st_ff.mode != MODE_OFF) begin
                            nxt_st.listen_primary_seen         = 1'b1;
                            nxt_st.talk_primary_seen         = 1'b0;
                            nxt_st.major_minor  = ~is_major;
                            nxt_st.prim_pending = 1'b1;
                        end
                    end
                    CMD_SECONDARY: begin
                        if (st_ff.mode == MODE_EXT && st_ff.prim_pending && hit_one) begin
                            nxt_st.send_addressed   = st_ff.talk_primary_seen;
                            nxt_st.listen_addressed = st_ff.listen_primary_seen;
                            nxt_st.addr_change      = 1'b1;
                            nxt_st.prim_pending     = 1'b0;
                        end else if (st_ff.mode == MODE_SOFT && (st_ff.talk_primary_seen || st_ff.listen_primary_seen)) begin
                            nxt_st.passthru       = bus_byte;
                            nxt_st.secondary_seen = 1'b1;
                            nxt_st.sec            = SEC_HOLD;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (st_ff.listen_addressed) begin
                nxt_st.in_byte       = bus_byte;
                nxt_st.inbound_ready = 1'b1;
            end
        end
        // outbound ready once atn released
        if (st_ff.send_addressed && !atn_asserted && !st_ff.out_full) begin
            nxt_st.outbound_ready = 1'b1;
        end
        // talker handshake on the bus
        if (st_ff.send_addressed && !atn_asserted && st_ff.out_full && !st_ff.dav_drive) begin
            nxt_st.dav_drive = 1'b1;
        end else if (st_ff.dav_drive && dac_asserted) begin
            nxt_st.dav_drive = 1'b0;
            nxt_st.out_full  = 1'b0;
        end
        nxt_st.talk_drive = st_ff.send_addressed & ~atn_asserted;
        // fly-by dma, one byte per acknowledge
        if (dma_ack && st_ff.dma_en) begin
            if (st_ff.send_addressed) begin
                nxt_st.out_byte       = dma_wdata;
                nxt_st.out_full       = 1'b1;
                nxt_st.outbound_ready = 1'b0;
            end else begin
                nxt_st.inbound_ready = 1'b0;
            end
        end
        // register writes
        if (acc_wr) begin
            case (avs_address)
                `OFS_MODE:      nxt_st.mode = addr_mode_t'(avs_writedata[1:0]);
                `OFS_SLOT_ZERO: nxt_st.slot_zero = avs_writedata[4:0];
                `OFS_SLOT_ONE:  nxt_st.slot_one = avs_writedata[4:0];
                `OFS_MASK_ONE:  nxt_st.sec_int_en = avs_writedata[`I1_SECONDARY];
                `OFS_DMA_CTRL:  nxt_st.dma_en = avs_writedata[0];
                `OFS_OUT_BYTE: begin
                    nxt_st.out_byte       = avs_writedata[7:0];
                    nxt_st.out_full       = 1'b1;
                    nxt_st.outbound_ready = 1'b0;
                end
                `OFS_AUX_CMD: begin
                    if (hold_dac && avs_writedata[7:0] == `AUX_VALID) begin
                        nxt_st.listen_addressed = st_ff.listen_primary_seen;
                        nxt_st.send_addressed   = st_ff.talk_primary_seen;
                        nxt_st.addr_change      = 1'b1;
                        nxt_st.sec              = SEC_IDLE;
                    end else if (hold_dac && avs_writedata[7:0] == `AUX_NON_VALID) begin
                        if (st_ff.talk_primary_seen) begin
                            nxt_st.send_addressed = 1'b0;
                        end
                        if (st_ff.listen_primary_seen) begin
                            nxt_st.listen_addressed = 1'b0;
                        end
                        nxt_st.sec = SEC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        // reads clear the event flags except outbound_ready; a same-cycle event still wins
        if (acc_rd) begin
            case (avs_address)
                `OFS_MODE:      nxt_st.rdata = {30'h0, st_ff.mode};
                `OFS_SLOT_ZERO: nxt_st.rdata = {27'h0, st_ff.slot_zero};
                `OFS_SLOT_ONE:  nxt_st.rdata = {27'h0, st_ff.slot_one};
                `OFS_STATE: begin
                    nxt_st.rdata = {25'h0, st_ff.active_ctl, ~atn_asserted, st_ff.talk_primary_seen, st_ff.listen_primary_seen,
                                    st_ff.send_addressed, st_ff.listen_addressed, st_ff.major_minor};
                end
                `OFS_INT_ONE: begin
                    nxt_st.rdata = {29'h0, st_ff.secondary_seen, st_ff.outbound_ready, st_ff.inbound_ready};
                    if (!(new_byte && atn_asserted && grp == CMD_SECONDARY)) begin
                        nxt_st.secondary_seen = nxt_st.secondary_seen & ~st_ff.secondary_seen;
                    end
                end
                `OFS_INT_TWO: begin
                    nxt_st.rdata = {31'h0, st_ff.addr_change};
                end
                `OFS_MASK_ONE:  nxt_st.rdata = {29'h0, st_ff.sec_int_en, 2'h0};
                `OFS_IN_BYTE: begin
                    nxt_st.rdata = {24'h0, st_ff.in_byte};
                    if (!(new_byte && !atn_asserted)) begin
                        nxt_st.inbound_ready = 1'b0;
                    end
                end
                `OFS_PASSTHRU:  nxt_st.rdata = {24'h0, st_ff.passthru};
                `OFS_DMA_CTRL:  nxt_st.rdata = {31'h0, st_ff.dma_en};
                default:        nxt_st.rdata = 32'h0;
            endcase
        end
        // active_ctl held at zero; own talk or listen sent as controller is not counted
        nxt_st.active_ctl = 1'b0;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff      <= '0;
            st_ff.mode <= addr_mode_t'(`RST_MODE);
        end else begin
            st_ff <= nxt_st;
        end
    end
    // outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~st_ff.ack;
    assign avs_readdata    = st_ff.rdata;
    assign dac_n_out       = 1'b0;
    // only an acceptor pulls: commands under atn, or data while listening
    assign dac_n_oe_n      = ~(hold_dac | (new_byte & (atn_asserted | st_ff.listen_addressed)));
    assign rfd_n_out       = 1'b0;
    assign rfd_n_oe_n      = ~(st_ff.listen_addressed & st_ff.inbound_ready);
    assign dav_n_out       = 1'b0;
    assign dav_n_oe_n      = ~st_ff.dav_drive;
    assign dio_n_out       = ~st_ff.out_byte;
    assign dio_n_oe_n      = ~st_ff.talk_drive;
    assign dma_req         = st_ff.dma_en & ~atn_asserted & ((st_ff.send_addressed & ~st_ff.out_full) |
                             (st_ff.listen_addressed & st_ff.inbound_ready));
    assign dma_rdata       = st_ff.in_byte;
    assign secondary_irq   = st_ff.secondary_seen & st_ff.sec_int_en;
endmodule
`default_nettype wire

/* File: tb/tlc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tlc_monitor (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // register bus
    input  wire logic avs_read,
    input  wire logic avs_write,
    input  wire logic avs_waitrequest,
    // instrument bus lines
    input  wire logic atn_n_in,
    input  wire logic dac_n_oe_n,
    input  wire logic rfd_n_oe_n,
    input  wire logic dav_n_oe_n,
    input  wire logic dio_n_oe_n,
    // dma and interrupt
    input  wire logic dma_req,
    input  wire logic dma_ack,
    input  wire logic secondary_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // every access starts with exactly one wait cycle
    a_req_waits: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("new access not held by waitrequest");
    a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not acknowledged after one wait");
    // handshake source only while the byte is on the lines
    a_talk_drives_data: assert property (!dav_n_oe_n |-> !dio_n_oe_n)
        else $error("data valid without data driven");
    // a talker takes no part as acceptor once atn has long been released
    a_talk_not_listen: assert property (!dio_n_oe_n && atn_n_in && $past(atn_n_in, 4)
        |-> rfd_n_oe_n && dac_n_oe_n)
        else $error("talker also acting as listener");
    // atn from the controller silences the talker within sync latency
    a_atn_stops_talk: assert property ($fell(atn_n_in) |-> ##[1:5] dio_n_oe_n)
        else $error("talker still driving under atn");
    // one request per byte
    a_ack_ends_req: assert property (dma_ack |=> !dma_req)
        else $error("dma request stands after its byte");
    a_irq_holds_dac: assert property ($rose(secondary_irq) |-> !dac_n_oe_n)
        else $error("secondary flagged without dac holdoff");
    // holdoff ends only through a software command
    a_holdoff_waits: assert property (secondary_irq && !dac_n_oe_n && !avs_write && !$past(avs_write)
        |=> !dac_n_oe_n)
        else $error("holdoff released without command");
endmodule
`default_nettype wire

/* File: tb/bus_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_far_end (
    // clock
    input  wire logic       core_clk,
    // device line enables and data
    input  wire logic       dac_n_oe_n,
    input  wire logic       rfd_n_oe_n,
    input  wire logic       dav_n_oe_n,
    input  wire logic       dio_n_oe_n,
    input  wire logic [7:0] dio_n_out,
    // resolved lines seen by the device
    output logic      [7:0] dio_n_in,
    output logic            atn_n_in,
    output logic            dav_n_in,
    output logic            dac_n_in
);
    logic [7:0] far_dio;
    logic       far_dav;
    logic       far_dac;

    // wired-and lines, terminations pull released lines high
    assign dio_n_in = far_dio & (dio_n_oe_n ? 8'hFF : dio_n_out);
    assign dav_n_in = far_dav & dav_n_oe_n;
    assign dac_n_in = far_dac & dac_n_oe_n;

    // controller in charge with atn asserted
    initial begin
        far_dio  = 8'hFF;
        far_dav  = 1'b1;
        far_dac  = 1'b0;
        atn_n_in = 1'b0;
    end

    // wait covers the device's input synchronisers
    task automatic set_atn(input logic on);
        @(posedge core_clk);
        atn_n_in <= ~on;
        repeat (5) @(posedge core_clk);
    endtask

    // source one byte, slow on purpose
    task automatic send(input logic [7:0] b, input logic cmd);
        @(posedge core_clk);
        atn_n_in <= ~cmd;
        far_dio  <= ~b;
        repeat (4) @(posedge core_clk);
        while (rfd_n_oe_n !== 1'b1) @(posedge core_clk);
        far_dav <= 1'b0;
        repeat (6) @(posedge core_clk);
        // a holdoff may keep dac low until software answers
        while (dac_n_oe_n !== 1'b1) @(posedge core_clk);
        far_dav <= 1'b1;
        far_dio <= 8'hFF;
    endtask

    // accept one byte from the device as talker
    task automatic recv(output logic [7:0] b);
        while (dav_n_oe_n !== 1'b0) @(posedge core_clk);
        @(posedge core_clk);
        b = ~dio_n_out;
        far_dac <= 1'b1;
        while (dav_n_oe_n !== 1'b1) @(posedge core_clk);
        far_dac <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/talk_listen_controller_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "addr_defines.svh"
module talk_listen_controller_test;
    logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  dio_n_in, dio_n_out, dma_wdata, dma_rdata, got;
    logic        atn_n_in, dav_n_in, dac_n_in, dac_n_oe_n, rfd_n_oe_n, dav_n_oe_n, dio_n_oe_n;
    logic        dma_req, dma_ack, secondary_irq;
    int          error_cnt, checks_done;

    talk_listen_controller talk_listen_controller_inst (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dio_n_in(dio_n_in), .atn_n_in(atn_n_in), .dav_n_in(dav_n_in),
        .dac_n_out(), .dac_n_oe_n(dac_n_oe_n), .rfd_n_out(), .rfd_n_oe_n(rfd_n_oe_n), .dav_n_out(),
        .dav_n_oe_n(dav_n_oe_n), .dio_n_out(dio_n_out), .dio_n_oe_n(dio_n_oe_n), .dac_n_in(dac_n_in),
        .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
        .secondary_irq(secondary_irq));

    bus_far_end bus_far_end_inst (
        .core_clk(core_clk), .dac_n_oe_n(dac_n_oe_n), .rfd_n_oe_n(rfd_n_oe_n), .dav_n_oe_n(dav_n_oe_n),
        .dio_n_oe_n(dio_n_oe_n), .dio_n_out(dio_n_out), .dio_n_in(dio_n_in), .atn_n_in(atn_n_in),
        .dav_n_in(dav_n_in), .dac_n_in(dac_n_in));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // avalon read, masked compare; data taken at the accepting edge
    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        @(posedge core_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
        chk($sformatf("reg_%0h", a), d & m, e);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, v};
        avs_write     <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    // secondary address answered by software; the source blocks meanwhile
    task automatic sec(input logic [7:0] sa, input logic [7:0] cmd);
        fork
            bus_far_end_inst.send(sa, 1'b1);
        join_none
        while (secondary_irq !== 1'b1) @(posedge core_clk);
        chk("dac_hold", {7'h00, dac_n_oe_n}, 8'h00);
        repeat (40) @(posedge core_clk);
        chk("dac_wait", {7'h00, dac_n_oe_n}, 8'h00);
        rc(`OFS_INT_ONE, 8'h04, 8'h04);
        rc(`OFS_PASSTHRU, 8'hFF, sa);
        wr(`OFS_AUX_CMD, cmd);
        wait fork;
    endtask

    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // a hang ends the run as a failure
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        reset_n       = 1'b0;
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h00000000;
        dma_ack       = 1'b0;
        dma_wdata     = 8'h00;
        error_cnt     = 0;
        checks_done   = 0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        // reset values and an unmapped place
        rc(`OFS_MODE, 8'hFF, {6'h00, `RST_MODE});
        rc(4'hF, 8'hFF, 8'h00);
        rc(`OFS_STATE, 8'hFF, 8'h00);
        // dual primaries: minor listen, one data byte in
        wr(`OFS_SLOT_ZERO, 8'h05);
        wr(`OFS_SLOT_ONE, 8'h09);
        bus_far_end_inst.send(8'h29, 1'b1);
        rc(`OFS_STATE, 8'hFF, 8'h03);
        rc(`OFS_INT_TWO, 8'h01, 8'h01);
        rc(`OFS_INT_TWO, 8'h01, 8'h00);
        bus_far_end_inst.send(8'h5A, 1'b0);
        chk("rfd_hold", {7'h00, rfd_n_oe_n}, 8'h00);
        rc(`OFS_INT_ONE, 8'h07, 8'h01);
        rc(`OFS_IN_BYTE, 8'hFF, 8'h5A);
        // listener side by fly-by dma: request while a byte waits
        wr(`OFS_DMA_CTRL, 8'h01);
        bus_far_end_inst.send(8'hA5, 1'b0);
        chk("dma_in", dma_rdata, 8'hA5);
        chk("dma_req_in", {7'h00, dma_req}, 8'h01);
        dma_ack <= 1'b1;
        @(posedge core_clk);
        dma_ack <= 1'b0;
        wr(`OFS_DMA_CTRL, 8'h00);
        rc(`OFS_INT_ONE, 8'h01, 8'h00);
        // major talk ends listening; byte out by pio, then fly-by dma
        bus_far_end_inst.send(8'h45, 1'b1);
        rc(`OFS_STATE, 8'hFF, 8'h04);
        rc(`OFS_INT_TWO, 8'h01, 8'h01);
        bus_far_end_inst.set_atn(1'b0);
        rc(`OFS_STATE, 8'hFF, 8'h24);
        rc(`OFS_INT_ONE, 8'h07, 8'h02);
        wr(`OFS_OUT_BYTE, 8'hC3);
        bus_far_end_inst.recv(got);
        chk("pio_out", got, 8'hC3);
        wr(`OFS_DMA_CTRL, 8'h01);
        while (dma_req !== 1'b1) @(posedge core_clk);
        dma_ack   <= 1'b1;
        dma_wdata <= 8'h3C;
        @(posedge core_clk);
        dma_ack <= 1'b0;
        bus_far_end_inst.recv(got);
        chk("dma_out", got, 8'h3C);
        repeat (3) @(posedge core_clk);
        chk("dma_req", {7'h00, dma_req}, 8'h01);
        wr(`OFS_DMA_CTRL, 8'h00);
        // extended: primary alone does not address
        wr(`OFS_MODE, 8'h02);
        wr(`OFS_SLOT_ONE, 8'h07);
        bus_far_end_inst.send(8'h25, 1'b1);
        rc(`OFS_STATE, 8'h0A, 8'h08);
        bus_far_end_inst.send(8'h67, 1'b1);
        rc(`OFS_STATE, 8'h06, 8'h02);
        rc(`OFS_INT_TWO, 8'h01, 8'h01);
        // software-judged secondaries
        wr(`OFS_MODE, 8'h03);
        wr(`OFS_MASK_ONE, 8'h04);
        wr(`OFS_SLOT_ONE, 8'h09);
        bus_far_end_inst.send(8'h45, 1'b1);
        rc(`OFS_STATE, 8'h11, 8'h10);
        sec(8'h63, `AUX_VALID);
        rc(`OFS_STATE, 8'h06, 8'h04);
        sec(8'h64, `AUX_NON_VALID);
        rc(`OFS_STATE, 8'h04, 8'h00);
        bus_far_end_inst.send(8'h29, 1'b1);
        rc(`OFS_STATE, 8'h18, 8'h08);
        bus_far_end_inst.send(8'h1F, 1'b1);
        rc(`OFS_STATE, 8'h18, 8'h00);
        print_verdict();
    end
endmodule

bind talk_listen_controller tlc_monitor tlc_monitor_inst (
    .core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .atn_n_in(atn_n_in), .dac_n_oe_n(dac_n_oe_n),
    .rfd_n_oe_n(rfd_n_oe_n), .dav_n_oe_n(dav_n_oe_n), .dio_n_oe_n(dio_n_oe_n), .dma_req(dma_req),
    .dma_ack(dma_ack), .secondary_irq(secondary_irq));
`default_nettype wire
